/* verilog/abs_defs.svh */
`ifndef ABS_DEFS_SVH
`define ABS_DEFS_SVH

// ***************************************************************
// Bus widths
// ***************************************************************
`define ABS_ADDR_W 22
`define ABS_DATA_W 16
`define ABS_BE_W   2

// ***************************************************************
// Byte enable values
// ***************************************************************
`define ABS_BE_FULL 2'h3
`define ABS_BE_LOW  2'h1
`define ABS_BE_HIGH 2'h2

// ***************************************************************
// Buffer and reset values
// ***************************************************************
`define ABS_BUF_DEPTH  2
`define ABS_RDATA_RST  16'h0000
`define ABS_ADDR_RST   22'h000000

`endif

/* verilog/abs_pkg.sv */
`default_nettype none
`include "abs_defs.svh"

package abs_pkg;

  typedef logic [`ABS_ADDR_W-1:0] abs_addr_t;
  typedef logic [`ABS_DATA_W-1:0] abs_data_t;
  typedef logic [`ABS_BE_W-1:0]   abs_be_t;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_PUSH   = 3'b010,
    ST_RDWAIT = 3'b011,
    ST_REPLY  = 3'b100,
    ST_INTR   = 3'b101
  } abs_state_e;

endpackage : abs_pkg

`default_nettype wire

/* verilog/abs_two_entry_buf.sv */
`timescale 1ns/1ns
`default_nettype none

// ***************************************************************
// Small FIFO; DEPTH must be a power of two
// ***************************************************************
module abs_two_entry_buf #(
  parameter int W     = 41,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  wire full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push  = ce && in_valid && !full;
  wire pop   = ce && out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

endmodule : abs_two_entry_buf

`default_nettype wire

/* verilog/abs_bus_slave.sv */
`timescale 1ns/1ns
`default_nettype none
`include "abs_defs.svh"

module abs_bus_slave (
  input  wire logic                CORE_CLK,
  input  wire logic                ARST_N,
  input  wire logic                CE,
  input  wire logic [21:0]         SHARED_DATA_ADDRESS_LINES_I,
  output logic [15:0]              SHARED_DATA_ADDRESS_LINES_O,
  output logic                     SHARED_DATA_ADDRESS_LINES_OE_N,
  input  wire logic                ADDRESS_SYNC_STROBE_N,
  input  wire logic                READ_DATA_STROBE_N,
  input  wire logic                WRITE_DATA_STROBE_N,
  input  wire logic                WRITE_BYTE_QUALIFIER_N,
  output logic                     SLAVE_REPLY_O,
  output logic                     SLAVE_REPLY_OE_N,
  output logic                     MEM_REQ_VALID,
  input  wire logic                MEM_REQ_READY,
  output logic                     MEM_REQ_WRITE,
  output abs_pkg::abs_be_t         MEM_REQ_BYTE_EN,
  output abs_pkg::abs_addr_t       MEM_REQ_ADDR,
  output abs_pkg::abs_data_t       MEM_REQ_WDATA,
  input  wire logic                MEM_RD_VALID,
  input  wire abs_pkg::abs_data_t  MEM_RD_DATA
);
  import abs_pkg::*;

  localparam int PIN_W = `ABS_ADDR_W + 4;
  localparam int REQ_W = 1 + `ABS_BE_W + `ABS_ADDR_W + `ABS_DATA_W;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // Lines and strobes share one pipe, so relative skew is kept
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] sync_r;
  abs_addr_t        dal_s;
  logic             wtbt_n_s;
  logic             wr_n_s;
  logic             rd_n_s;
  logic             as_n_s;

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      meta_r <= '1;
      sync_r <= '1;
    end
    else if (CE)
    begin
      meta_r <= {WRITE_BYTE_QUALIFIER_N, WRITE_DATA_STROBE_N, READ_DATA_STROBE_N,
                 ADDRESS_SYNC_STROBE_N, SHARED_DATA_ADDRESS_LINES_I};
      sync_r <= meta_r;
    end
  end

  assign {wtbt_n_s, wr_n_s, rd_n_s, as_n_s, dal_s} = sync_r;

  wire as_s   = !as_n_s;
  wire rd_s   = !rd_n_s;
  wire wr_s   = !wr_n_s;
  wire wtbt_s = !wtbt_n_s;

  // ***************************************************************
  // Transfer state
  // ***************************************************************
  abs_state_e state_r;
  abs_state_e st_nxt;
  abs_addr_t  addr_r;
  abs_data_t  wdata_r;
  abs_data_t  rdata_r;
  logic       is_write_r;
  logic       byte_r;
  logic       op_wr_r;
  logic       dal_oe_n_r;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [REQ_W-1:0] buf_out_data;

  wire strobe_gone = op_wr_r ? !wr_s : !rd_s;

  always_comb
  begin
    st_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (as_s)
          st_nxt = ST_ADDR;
        else if (rd_s)
          st_nxt = ST_INTR;
      end
      ST_ADDR:
      begin
        if (!as_s)
          st_nxt = ST_IDLE;
        else if (wr_s || rd_s)
          st_nxt = ST_PUSH;
      end
      ST_PUSH:
      begin
        if (!as_s)
          st_nxt = ST_IDLE;
        else if (buf_in_ready)
          st_nxt = op_wr_r ? ST_REPLY : ST_RDWAIT;
      end
      ST_RDWAIT:
      begin
        // Read stays owed even if sync drops, or data would misalign
        if (MEM_RD_VALID)
          st_nxt = ST_REPLY;
      end
      ST_REPLY:
      begin
        if (!as_s)
          st_nxt = ST_IDLE;
        else if (strobe_gone)
          st_nxt = ST_ADDR;
      end
      ST_INTR:
      begin
        if (!rd_s)
          st_nxt = ST_IDLE;
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  wire cap_addr   = (state_r == ST_IDLE) && as_s;
  wire cap_op     = (state_r == ST_ADDR) && as_s && (wr_s || rd_s);
  wire take_rd    = (state_r == ST_RDWAIT) && MEM_RD_VALID;
  wire leave_rply = (state_r == ST_REPLY) && (st_nxt != ST_REPLY);

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_r <= ST_IDLE;
    end
    else if (CE)
    begin
      state_r <= st_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      addr_r     <= `ABS_ADDR_RST;
      is_write_r <= 1'b0;
    end
    else if (CE && cap_addr)
    begin
      addr_r     <= dal_s;
      is_write_r <= wtbt_s;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wdata_r <= `ABS_RDATA_RST;
      byte_r  <= 1'b0;
      op_wr_r <= 1'b0;
    end
    else if (CE && cap_op)
    begin
      wdata_r <= dal_s[`ABS_DATA_W-1:0];
      byte_r  <= wr_s && wtbt_s;
      op_wr_r <= wr_s;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rdata_r    <= `ABS_RDATA_RST;
      dal_oe_n_r <= 1'b1;
    end
    else if (CE)
    begin
      if (take_rd)
      begin
        rdata_r    <= MEM_RD_DATA;
        dal_oe_n_r <= 1'b0;
      end
      else if (leave_rply)
      begin
        dal_oe_n_r <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Request buffer toward memory
  // ***************************************************************
  // Only the addressed byte is enabled on a byte write
  wire abs_be_t be_sel = byte_r ? (addr_r[0] ? `ABS_BE_HIGH : `ABS_BE_LOW)
                                : `ABS_BE_FULL;
  wire buf_push = (state_r == ST_PUSH) && as_s;

  abs_two_entry_buf #(
    .W     (REQ_W),
    .DEPTH (`ABS_BUF_DEPTH)
  ) u_req_buf (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .ce        (CE),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   ({op_wr_r, be_sel, addr_r, wdata_r}),
    .out_valid (buf_out_valid),
    .out_ready (MEM_REQ_READY),
    .out_data  (buf_out_data)
  );

  assign MEM_REQ_VALID = buf_out_valid;
  assign {MEM_REQ_WRITE, MEM_REQ_BYTE_EN, MEM_REQ_ADDR, MEM_REQ_WDATA} = buf_out_data;

  // ***************************************************************
  // Bus drivers
  // ***************************************************************
  wire reply_on = (state_r == ST_REPLY);

  assign SLAVE_REPLY_O                  = 1'b0;
  assign SLAVE_REPLY_OE_N               = !reply_on;
  assign SHARED_DATA_ADDRESS_LINES_O    = rdata_r;
  assign SHARED_DATA_ADDRESS_LINES_OE_N = dal_oe_n_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_write_reply: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (state_r == ST_PUSH && as_s && buf_in_ready && op_wr_r) |=> reply_on)
    else $error("write not answered by reply");

  a_reply_cause: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    $rose(reply_on) |-> ($past(state_r) == ST_PUSH || $past(state_r) == ST_RDWAIT))
    else $error("reply without taken data");

  a_read_start: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (state_r == ST_ADDR && as_s && rd_s && !wr_s) |=> (state_r == ST_PUSH && !op_wr_r))
    else $error("read strobe in sync not taken");

  a_intr_ignored: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (state_r == ST_IDLE && !as_s && rd_s) |=> (state_r == ST_INTR && !reply_on) [*2])
    else $error("read without sync treated as memory read");

  a_addr_capture: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (state_r == ST_IDLE && as_s) |=> (addr_r == $past(dal_s) && state_r == ST_ADDR))
    else $error("address not captured at sync");

  a_sync_end: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (!as_s && state_r != ST_RDWAIT && state_r != ST_INTR
     && !(state_r == ST_IDLE && rd_s)) |=> state_r == ST_IDLE)
    else $error("transfer outlived sync");

  a_write_flag: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (state_r == ST_IDLE && as_s) |=> is_write_r == $past(wtbt_s))
    else $error("write qualifier not captured");

  a_byte_lane: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (MEM_REQ_VALID && MEM_REQ_WRITE && MEM_REQ_BYTE_EN != 2'h3)
      |-> (MEM_REQ_BYTE_EN == (MEM_REQ_ADDR[0] ? 2'h2 : 2'h1)))
    else $error("byte write enables wrong lane");

  a_reply_release: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    (reply_on && strobe_gone) |=> (!reply_on && dal_oe_n_r))
    else $error("reply or data held after strobe");

  a_drive_window: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !CE)
    !dal_oe_n_r |-> (reply_on && !op_wr_r))
    else $error("data driven outside read reply");

endmodule : abs_bus_slave

`default_nettype wire

/* tb/abs_master_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ***************************************************************
// Bus master partner, acts on falling edges
// ***************************************************************
module abs_master_model (
  input  wire logic        clk,
  input  wire logic [21:0] bus,
  input  wire logic        reply_n,
  output logic [21:0]      lines,
  output logic             sync_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             wtbt_n
);
  initial
  begin
    lines  = 22'h3FFFFF;
    sync_n = 1'b1;
    rd_n   = 1'b1;
    wr_n   = 1'b1;
    wtbt_n = 1'b1;
  end

  task automatic xfer(input logic wr, input logic byt, input logic [21:0] a,
                      input logic [15:0] d, output logic [15:0] q, output int n);
    lines  = a;
    wtbt_n = !wr;
    sync_n = 1'b0;
    repeat (3) @(negedge clk);
    lines  = wr ? {~a[21:16], d} : ~a;
    wtbt_n = !byt;
    // Strobe a cycle after data, so the lines have settled
    @(negedge clk);
    if (wr)
      wr_n = 1'b0;
    else
      rd_n = 1'b0;
    n = 0;
    while (reply_n !== 1'b0 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    q      = bus[15:0];
    wr_n   = 1'b1;
    rd_n   = 1'b1;
    wtbt_n = 1'b1;
    repeat (4) @(negedge clk);
    sync_n = 1'b1;
    lines  = ~lines;
    repeat (3) @(negedge clk);
  endtask : xfer

  task automatic intr(output int n);
    rd_n = 1'b0;
    n    = 0;
    repeat (20)
    begin
      @(negedge clk);
      if (reply_n === 1'b0)
        n++;
    end
    rd_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : intr
endmodule : abs_master_model

`default_nettype wire

/* tb/abs_bus_slave_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module abs_bus_slave_bench;
  import abs_pkg::*;
  logic        clk, arst_n, stall, rd_valid, reply_w, ce, pop_wr;
  logic        sync_n, rd_n, wr_n, wtbt_n, dout_oe_n, rep_o, rep_oe_n;
  logic        req_valid, req_write;
  logic [15:0] rd_data, dout, q;
  logic [21:0] lines, bus;
  abs_be_t     req_be, pop_be;
  abs_addr_t   req_addr, pop_addr;
  abs_data_t   req_wdata, pop_wd;
  logic [15:0] mem [16] = '{default: 16'h0000};
  logic [15:0] pend [$];
  int          bad_count, checks, cyc, pops, n, p0;

  // Open drain reply pulls up; data lines shared with the master
  assign reply_w = rep_oe_n ? 1'b1 : rep_o;
  assign bus     = dout_oe_n ? lines : {lines[21:16], dout};

  abs_bus_slave u_abs_bus_slave (
    .CORE_CLK(clk), .ARST_N(arst_n), .CE(ce),
    .SHARED_DATA_ADDRESS_LINES_I(bus), .SHARED_DATA_ADDRESS_LINES_O(dout),
    .SHARED_DATA_ADDRESS_LINES_OE_N(dout_oe_n), .ADDRESS_SYNC_STROBE_N(sync_n),
    .READ_DATA_STROBE_N(rd_n), .WRITE_DATA_STROBE_N(wr_n),
    .WRITE_BYTE_QUALIFIER_N(wtbt_n), .SLAVE_REPLY_O(rep_o),
    .SLAVE_REPLY_OE_N(rep_oe_n), .MEM_REQ_VALID(req_valid), .MEM_REQ_READY(!stall),
    .MEM_REQ_WRITE(req_write), .MEM_REQ_BYTE_EN(req_be), .MEM_REQ_ADDR(req_addr),
    .MEM_REQ_WDATA(req_wdata), .MEM_RD_VALID(rd_valid), .MEM_RD_DATA(rd_data)
  );

  abs_master_model u_abs_master_model (
    .clk(clk), .bus(bus), .reply_n(reply_w), .lines(lines), .sync_n(sync_n),
    .rd_n(rd_n), .wr_n(wr_n), .wtbt_n(wtbt_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ***************************************************************
  // Memory stand-in; answers reads half a cycle after the pop, on the falling edge
  // ***************************************************************
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
    if (arst_n && ce && req_valid && !stall)
    begin
      pops++;
      pop_wr   = req_write;
      pop_be   = req_be;
      pop_addr = req_addr;
      pop_wd   = req_wdata;
      if (!req_write)
        pend.push_back(mem[req_addr[4:1]]);
      if (req_write && req_be[0])
        mem[req_addr[4:1]][7:0] = req_wdata[7:0];
      if (req_write && req_be[1])
        mem[req_addr[4:1]][15:8] = req_wdata[15:8];
    end
  end

  always @(negedge clk)
  begin
    rd_valid = 1'b0;
    if (pend.size() > 0)
    begin
      rd_valid = 1'b1;
      rd_data  = pend.pop_front();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_word;
    u_abs_master_model.xfer(1'b1, 1'b0, 22'h3C0004, 16'hA5C3, q, n);
    chk("write reply", n < 60, 1);
    chk("write flag", pop_wr, 1);
    chk("word enables", pop_be, 2'h3);
    chk("write addr", pop_addr, 22'h3C0004);
    chk("write data", pop_wd, 16'hA5C3);
    u_abs_master_model.xfer(1'b0, 1'b0, 22'h3C0004, 16'h0000, q, n);
    chk("read reply", n < 60, 1);
    chk("read flag", pop_wr, 0);
    chk("read data", q, 16'hA5C3);
    chk("data oe", dout_oe_n, 1);
    chk("reply oe", rep_oe_n, 1);
  endtask : t_word

  // Enable low half a cycle before the reply would be asserted holds the transfer in ST_PUSH and delays the push and the reply
  task automatic t_ce;
    fork
      u_abs_master_model.xfer(1'b1, 1'b0, 22'h000020, 16'h5A5A, q, n);
      begin
        repeat (7) @(negedge clk);
        ce = 1'b0;
        repeat (20) @(negedge clk);
        ce = 1'b1;
      end
    join
    chk("frozen reply", n >= 20 && n < 60, 1);
    chk("frozen addr", pop_addr, 22'h000020);
    chk("frozen data", pop_wd, 16'h5A5A);
  endtask : t_ce

  task automatic t_byte;
    u_abs_master_model.xfer(1'b1, 1'b0, 22'h000008, 16'h1234, q, n);
    u_abs_master_model.xfer(1'b1, 1'b1, 22'h000008, 16'h00EE, q, n);
    chk("low lane", pop_be, 2'h1);
    u_abs_master_model.xfer(1'b1, 1'b1, 22'h000009, 16'h7700, q, n);
    chk("high lane", pop_be, 2'h2);
    u_abs_master_model.xfer(1'b0, 1'b0, 22'h000008, 16'h0000, q, n);
    chk("merged", q, 16'h77EE);
  endtask : t_byte

  task automatic t_intr;
    p0 = pops;
    u_abs_master_model.intr(n);
    chk("intr reply", n, 0);
    chk("intr pops", pops, p0);
  endtask : t_intr

  // Memory stalls: two writes fit, third waits for a pop
  task automatic t_full;
    p0    = pops;
    stall = 1'b1;
    u_abs_master_model.xfer(1'b1, 1'b0, 22'h000010, 16'h1111, q, n);
    chk("buf 1", n < 60, 1);
    u_abs_master_model.xfer(1'b1, 1'b0, 22'h000012, 16'h2222, q, n);
    chk("buf 2", n < 60, 1);
    chk("held", req_valid, 1);
    fork
      u_abs_master_model.xfer(1'b1, 1'b0, 22'h000014, 16'h3333, q, n);
      begin
        repeat (20) @(negedge clk);
        stall = 1'b0;
      end
    join
    chk("full wait", n >= 15 && n < 60, 1);
    chk("drained", pops - p0, 3);
    chk("empty", req_valid, 0);
    u_abs_master_model.xfer(1'b0, 1'b0, 22'h000014, 16'h0000, q, n);
    chk("last", q, 16'h3333);
  endtask : t_full

  initial
  begin
    arst_n = 1'b0;
    stall  = 1'b0;
    ce     = 1'b1;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    chk("reset reply", rep_oe_n, 1);
    chk("reset data", dout_oe_n, 1);
    chk("reset valid", req_valid, 0);
    t_word();
    t_ce();
    t_byte();
    t_intr();
    t_full();
    give_verdict();
  end
endmodule : abs_bus_slave_bench

`default_nettype wire
